// [design/acc_ctrl.v]
/*
 * calibration sequencer, range flagging and 1:2 output split of an
 * 8-bit sampling converter, with a small register port.
 * assumes sample codes arrive on clk each cycle with clip flags from
 * the analog core; pin inputs are asynchronous and synchronised here.
 */
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "acc_regs.vh"

module acc_ctrl #(
   parameter WAIT_SHORT = `ACC_WAIT_SHORT_CYC,
   parameter WAIT_LONG = `ACC_WAIT_LONG_CYC,
   parameter TRIG_LOW = `ACC_TRIG_LOW_CYC,
   parameter TRIG_HIGH = `ACC_TRIG_HIGH_CYC,
   parameter TRIM_RUN = `ACC_TRIM_RUN_CYC,
   parameter CNT_W = 16
) (
   input wire clk,
   input wire reset,
   input wire clk_en,
   input wire [7:0] sample_code,
   input wire sample_clip_low,
   input wire sample_clip_high,
   input wire trim_request,
   input wire sleep_request,
   input wire startup_wait_select,
   input wire range_select,
   input wire swing_select,
   input wire launch_edge_select,
   input wire extended_mode_enable,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg [7:0] direct_bus,
   output reg [7:0] delayed_bus,
   output reg out_of_range_flag,
   output reg capture_clock_out,
   output wire outputs_oe,
   output reg trim_in_progress,
   output wire swing_level,
   output wire launch_edge,
   output wire range_level
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam NSYNC = 7;
   wire [NSYNC-1:0] pin_raw;
   reg [NSYNC-1:0] sync1_q;
   reg [NSYNC-1:0] sync2_q;
   assign pin_raw = {extended_mode_enable, launch_edge_select,
      swing_select, range_select, startup_wait_select, sleep_request,
      trim_request};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge clk) begin
            if (reset) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end else if (clk_en) begin
               sync1_q[gi] <= pin_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate
   wire trig_s = sync2_q[0];
   wire sleep_s = sync2_q[1];

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   reg [7:0] cfg_q;
   reg soft_trim_q;
   reg ext_q;
   reg ext_seen_q;
   reg [1:0] ext_cnt_q;
   wire wr_cfg = reg_wr && reg_addr == `ACC_ADDR_CFG;
   always @(posedge clk) begin
      if (reset) begin
         cfg_q <= `ACC_CFG_RESET;
         soft_trim_q <= 1'b0;
         ext_q <= 1'b0;
         ext_seen_q <= 1'b0;
         ext_cnt_q <= 2'h0;
      end else if (clk_en) begin
         // mode caught once after reset, then held
         if (!ext_seen_q) begin
            ext_cnt_q <= ext_cnt_q + 2'h1;
            // pin settles through the synchroniser first
            if (ext_cnt_q == 2'h2) begin
               ext_q <= sync2_q[6];
               ext_seen_q <= 1'b1;
            end
         end
         if (wr_cfg)
            cfg_q <= reg_wdata;
         soft_trim_q <= reg_wr && reg_addr == `ACC_ADDR_CTRL &&
            reg_wdata[`ACC_CTRL_SOFT_TRIM] && ext_q;
      end
   end

   // extended mode ignores the setting pins
   assign swing_level = ext_q ? cfg_q[`ACC_CFG_SWING] : sync2_q[4];
   assign launch_edge = ext_q ? cfg_q[`ACC_CFG_EDGE] : sync2_q[5];
   assign range_level = ext_q ? cfg_q[`ACC_CFG_RANGE] : sync2_q[3];
   // extended mode always takes the short wait
   wire wait_long = ext_q ? 1'b0 : sync2_q[2];

   // ----------------------------------------------------------------
   // calibration sequencer
   // ----------------------------------------------------------------
   localparam S_WAIT = 5'b00001;
   localparam S_IDLE = 5'b00010;
   localparam S_LOW = 5'b00100;
   localparam S_HIGH = 5'b01000;
   localparam S_TRIM = 5'b10000;
   reg [4:0] state_q;
   reg [CNT_W-1:0] cnt_q;
   reg armed_q;
   reg asleep_q;
   wire [CNT_W-1:0] wait_len = wait_long ? WAIT_LONG[CNT_W-1:0] :
      WAIT_SHORT[CNT_W-1:0];
   wire [CNT_W-1:0] cnt_inc = cnt_q + 1'b1;
   // soft trim taken only in idle, low or high, never in start-up wait, calibration or sleep
   wire soft_go = soft_trim_q && !sleep_s && !asleep_q &&
      (state_q == S_IDLE || state_q == S_LOW || state_q == S_HIGH);

   always @(posedge clk) begin
      if (reset) begin
         state_q <= S_WAIT;
         cnt_q <= {CNT_W{1'b0}};
         armed_q <= 1'b1;
         asleep_q <= 1'b0;
         trim_in_progress <= 1'b0;
      end else if (clk_en) begin
         // power-down only entered outside calibration
         if (state_q != S_TRIM)
            asleep_q <= sleep_s;
         case (state_q)
            S_WAIT: begin
               if (sleep_s) begin
                  cnt_q <= cnt_q;
               end else if (cnt_q >= wait_len - 1'b1) begin
                  cnt_q <= {CNT_W{1'b0}};
                  // request high at power-up holds off
                  if (trig_s) begin
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_TRIM;
                     trim_in_progress <= 1'b1;
                     armed_q <= 1'b0;
                  end
               end else begin
                  cnt_q <= cnt_inc;
               end
            end
            S_IDLE: begin
               cnt_q <= {CNT_W{1'b0}};
               if (sleep_s) begin
                  state_q <= S_IDLE;
               end else if (!trig_s) begin
                  state_q <= S_LOW;
               end
            end
            S_LOW: begin
               if (sleep_s) begin
                  state_q <= S_IDLE;
               end else if (trig_s) begin
                  // first high sample counts toward the minimum
                  cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1};
                  // low phase long enough
                  state_q <= (cnt_q >= TRIG_LOW[CNT_W-1:0] - 1'b1) ?
                     S_HIGH : S_IDLE;
               end else if (cnt_q < TRIG_LOW[CNT_W-1:0]) begin
                  cnt_q <= cnt_inc;
               end
            end
            S_HIGH: begin
               if (sleep_s || !trig_s) begin
                  state_q <= sleep_s ? S_IDLE : S_LOW;
                  cnt_q <= {CNT_W{1'b0}};
               end else if (cnt_q >= TRIG_HIGH[CNT_W-1:0] - 1'b1) begin
                  cnt_q <= {CNT_W{1'b0}};
                  state_q <= S_TRIM;
                  trim_in_progress <= 1'b1;
                  armed_q <= 1'b0;
               end else begin
                  cnt_q <= cnt_inc;
               end
            end
            S_TRIM: begin
               // flag covers whole calibration
               if (cnt_q >= TRIM_RUN[CNT_W-1:0] - 1'b1) begin
                  cnt_q <= {CNT_W{1'b0}};
                  state_q <= S_IDLE;
                  trim_in_progress <= 1'b0;
               end else begin
                  cnt_q <= cnt_inc;
               end
            end
            default: begin
               state_q <= S_IDLE;
               cnt_q <= {CNT_W{1'b0}};
               trim_in_progress <= 1'b0;
            end
         endcase
         if (soft_go) begin
            state_q <= S_TRIM;
            cnt_q <= {CNT_W{1'b0}};
            trim_in_progress <= 1'b1;
            armed_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // conversion pipeline
   // ----------------------------------------------------------------
   localparam LAT = `ACC_LAT_DIRECT;
   // halted clocks: pipeline frozen in calibration
   wire run = clk_en && !trim_in_progress;
   reg [7:0] pipe_q [0:LAT-1];
   reg [LAT-1:0] oor_q;
   reg phase_q;
   reg [7:0] held_q;
   reg held_oor_q;
   reg [7:0] word_d;
   always @* begin
      word_d = sample_code; // offset binary as is
      if (sample_clip_low)
         word_d = 8'h00;
      else if (sample_clip_high)
         word_d = 8'hff;
   end
   generate
      for (gi = 0; gi < LAT; gi = gi + 1) begin : g_pipe
         always @(posedge clk) begin
            if (reset) begin
               pipe_q[gi] <= 8'h00;
               oor_q[gi] <= 1'b0;
            end else if (run) begin
               pipe_q[gi] <= (gi == 0) ? word_d :
                  pipe_q[(gi == 0) ? 0 : gi-1];
               oor_q[gi] <= (gi == 0) ?
                  (sample_clip_low | sample_clip_high) :
                  oor_q[(gi == 0) ? 0 : gi-1];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // 1:2 output split and capture clock
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         phase_q <= 1'b0;
         held_q <= 8'h00;
         held_oor_q <= 1'b0;
         direct_bus <= 8'h00;
         delayed_bus <= 8'h00;
         out_of_range_flag <= 1'b0;
         capture_clock_out <= 1'b0;
      end else if (run) begin
         phase_q <= ~phase_q;
         held_q <= pipe_q[LAT-1];
         held_oor_q <= oor_q[LAT-1];
         capture_clock_out <= ~phase_q;
         if (phase_q) begin
            // direct word 13, delayed word 14 cycles
            direct_bus <= pipe_q[LAT-1];
            delayed_bus <= held_q;
            out_of_range_flag <= oor_q[LAT-1] | held_oor_q;
         end
      end
   end
   assign outputs_oe = !asleep_q;

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `ACC_ADDR_STAT:
                  reg_rdata <= {4'h0, armed_q, out_of_range_flag,
                     asleep_q, trim_in_progress};
               `ACC_ADDR_CFG:
                  reg_rdata <= cfg_q;
               `ACC_ADDR_PERIOD:
                  reg_rdata <= {7'h00, wait_long};
               default:
                  reg_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule

// [design/acc_regs.vh]
/*
 * constants for the converter calibration and output control block.
 * assumes a 100 MHz control clock; included by the design file.
 */
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACC_ADDR_CTRL 4'h0
`define ACC_ADDR_STAT 4'h1
`define ACC_ADDR_CFG 4'h2
`define ACC_ADDR_PERIOD 4'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACC_CTRL_SOFT_TRIM 0
`define ACC_STAT_TRIM 0
`define ACC_STAT_SLEEP 1
`define ACC_STAT_OOR 2
`define ACC_STAT_ARMED 3
`define ACC_CFG_SWING 0
`define ACC_CFG_EDGE 1
`define ACC_CFG_RANGE 2
`define ACC_CFG_WAIT 3

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define ACC_CFG_RESET 8'h00
`define ACC_TRIG_LOW_CYC 1280
`define ACC_TRIG_HIGH_CYC 1280
`define ACC_WAIT_SHORT_CYC 4096
`define ACC_WAIT_LONG_CYC 16384
`define ACC_TRIM_RUN_CYC 2048
`define ACC_LAT_DIRECT 13
`define ACC_LAT_DELAYED 14

`endif

// [test/acc_props.sv]
/* assertions on the ports of the calibration and output control block.
   assumes a bind to every acc_ctrl instance, one clock domain. */
`timescale 1ns/10ps
module acc_props (
   input wire clk,
   input wire reset,
   input wire [3:0] reg_addr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire [7:0] direct_bus,
   input wire capture_clock_out,
   input wire outputs_oe,
   input wire trim_in_progress
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_trim_keeps_oe: assert property (
      trim_in_progress |-> outputs_oe) else $error("sleep during trim");
   a_clock_halted: assert property (
      trim_in_progress && $past(trim_in_progress) |->
      $stable(capture_clock_out)) else $error("clock ran in trim");
   a_bus_frozen: assert property (
      trim_in_progress && $past(trim_in_progress) |->
      $stable(direct_bus)) else $error("bus moved in trim");
   a_trim_held: assert property (
      $rose(trim_in_progress) |-> trim_in_progress[*8])
      else $error("trim flag too short");
   a_no_trim_asleep: assert property (
      $rose(trim_in_progress) |-> $past(outputs_oe))
      else $error("trim started asleep");
   a_stat_trim_bit: assert property (
      $past(reg_rd) && $past(reg_addr) == 4'h1 |->
      reg_rdata[0] == $past(trim_in_progress)) else $error("stat bit");
   a_bus_pair_edge: assert property (
      $changed(direct_bus) |-> $fell(capture_clock_out))
      else $error("bus change off clock");
   a_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata idle");
endmodule
bind acc_ctrl acc_props acc_props_i (.clk(clk), .reset(reset),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .direct_bus(direct_bus), .capture_clock_out(capture_clock_out),
   .outputs_oe(outputs_oe), .trim_in_progress(trim_in_progress));

// [test/acc_rx.sv]
/* capture receiver: pairs the two buses on each data clock rise while outputs are enabled and no calibration runs.
   assumes it shares the sample clock and samples the data clock. */
`timescale 1ns/10ps
module acc_rx (
   input wire clk,
   input wire reset,
   input wire capture_clock_out,
   input wire outputs_oe,
   input wire trim_in_progress,
   input wire [7:0] direct_bus,
   input wire [7:0] delayed_bus,
   output reg [15:0] pair_q
);
   reg cap_q;
   // data clock sampled, not used as a clock
   always @(posedge clk) begin
      cap_q <= capture_clock_out;
      if (reset) begin
         pair_q <= 16'h0000;
      end else if (capture_clock_out && !cap_q && outputs_oe &&
                   !trim_in_progress) begin
         pair_q <= {delayed_bus, direct_bus};
      end
   end
endmodule

// [test/tb_acc_ctrl.sv]
/* self-checking bench for acc_ctrl with short simulation counts.
   assumes the receiver model acc_rx and the bound checker. */
`timescale 1ns/10ps
module tb_acc_ctrl;
   reg clk = 1'b0, reset = 1'b1, clk_en = 1'b1, trim_request = 1'b0;
   reg sample_clip_low = 1'b0, sample_clip_high = 1'b0;
   reg sleep_request = 1'b0, startup_wait_select = 1'b0;
   reg range_select = 1'b0, swing_select = 1'b0;
   reg launch_edge_select = 1'b0, extended_mode_enable = 1'b0;
   reg reg_wr = 1'b0, reg_rd = 1'b0;
   reg [7:0] sample_code = 8'h55, reg_wdata = 8'h00, d, m;
   reg [3:0] reg_addr = 4'h0;
   wire [7:0] reg_rdata, direct_bus, delayed_bus;
   wire [15:0] pair_q;
   wire out_of_range_flag, capture_clock_out, outputs_oe;
   wire trim_in_progress, swing_level, launch_edge, range_level;
   integer failures = 0, n_compared = 0, n, k;
   reg seen;
   acc_ctrl #(.WAIT_SHORT(20), .WAIT_LONG(40), .TRIG_LOW(4),
      .TRIG_HIGH(4), .TRIM_RUN(10)) acc_ctrl_i (.clk(clk),
      .reset(reset), .clk_en(clk_en), .sample_code(sample_code),
      .sample_clip_low(sample_clip_low),
      .sample_clip_high(sample_clip_high), .trim_request(trim_request),
      .sleep_request(sleep_request),
      .startup_wait_select(startup_wait_select),
      .range_select(range_select), .swing_select(swing_select),
      .launch_edge_select(launch_edge_select),
      .extended_mode_enable(extended_mode_enable), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .direct_bus(direct_bus),
      .delayed_bus(delayed_bus), .out_of_range_flag(out_of_range_flag),
      .capture_clock_out(capture_clock_out), .outputs_oe(outputs_oe),
      .trim_in_progress(trim_in_progress), .swing_level(swing_level),
      .launch_edge(launch_edge), .range_level(range_level));
   acc_rx acc_rx_i (.clk(clk), .reset(reset),
      .capture_clock_out(capture_clock_out), .outputs_oe(outputs_oe),
      .trim_in_progress(trim_in_progress), .direct_bus(direct_bus),
      .delayed_bus(delayed_bus), .pair_q(pair_q));
   always #5 clk = ~clk;
   // ----
   // shared tasks
   // ----
   task finish_test;
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input [8*6:1] name, input [7:0] exp, input [7:0] got);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("[ERR] %0s exp %h got %h", name, exp, got);
      end
   endtask
   task tick(input integer c);
      repeat (c) @(posedge clk);
   endtask
   task wtrim(input lvl, input integer bound);
      n = 0;
      while (trim_in_progress !== lvl && n < bound) begin
         @(posedge clk);
         #1;
         n = n + 1;
      end
      if (n >= bound) begin
         failures = failures + 1;
         finish_test;
      end
   endtask
   task rd(input [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task wr(input [3:0] a, input [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task cmd;
      @(posedge clk);
      trim_request <= 1'b0;
      tick(6);
      trim_request <= 1'b1;
   endtask
   task idle(input integer c);
      seen = 1'b0;
      repeat (c) begin
         @(posedge clk);
         #1 seen = seen | trim_in_progress;
      end
   endtask
   // ----
   // scenarios
   // ----
   task boot(input sel, input integer w, input slp);
      @(posedge clk);
      reset <= 1'b1;
      startup_wait_select <= sel;
      sleep_request <= slp;
      trim_request <= 1'b0;
      tick(4);
      reset <= 1'b0;
      #1 chk("oe", 8'h01, {7'h0, outputs_oe});
      if (slp) begin
         idle(60);
         chk("slpoe", 8'h00, {7'h0, outputs_oe});
         chk("slptr", 8'h00, {7'h0, seen});
         @(posedge clk);
         sleep_request <= 1'b0;
      end
      wtrim(1'b1, 200);
      chk("wait", 8'h01, {7'h0, n >= w && n < w + 6});
      wtrim(1'b0, 50);
      chk("trlen", 8'h0a, n[7:0]);
   endtask
   task t_regs;
      rd(4'h2);
      chk("cfg", 8'h00, d);
      wr(4'h2, 8'h07);
      rd(4'h2);
      chk("cfgwr", 8'h07, d);
      rd(4'h9);
      chk("unmap", 8'h00, d);
      rd(4'h1);
      chk("stat", 8'h00, {7'h0, d[0]});
      @(posedge clk);
      clk_en <= 1'b0;
      wr(4'h2, 8'h03);
      @(posedge clk);
      clk_en <= 1'b1;
      rd(4'h2);
      chk("frozen", 8'h07, d);
   endtask
   task t_data;
      for (k = 0; k < 4; k = k + 1) begin
         m = (k < 2) ? 8'ha0 + k : 8'h80;
         @(posedge clk);
         sample_code <= m;
         sample_clip_low <= (k == 2);
         sample_clip_high <= (k == 3);
         @(posedge clk);
         sample_code <= 8'h55;
         sample_clip_low <= 1'b0;
         sample_clip_high <= 1'b0;
         if (k > 1) m = (k == 3) ? 8'hff : 8'h00;
         n = 0;
         while (direct_bus !== m && delayed_bus !== m && n < 40) begin
            @(posedge clk);
            #1 n = n + 1;
         end
         chk("lat", (direct_bus === m) ? 8'h0d : 8'h0e, n[7:0]);
         chk("oor", {7'h0, k > 1}, {7'h0, out_of_range_flag});
         tick(3);
         #1 chk("rx", 8'h01, {7'h0, pair_q[7:0] === m ||
            pair_q[15:8] === m});
      end
   endtask
   task t_sleep;
      cmd;
      wtrim(1'b1, 20);
      chk("cmdlat", 8'h01, {7'h0, n >= 4 && n < 9});
      @(posedge clk);
      sleep_request <= 1'b1;
      wtrim(1'b0, 50);
      tick(4);
      #1 chk("defer", 8'h00, {7'h0, outputs_oe});
      cmd;
      idle(30);
      @(posedge clk);
      sleep_request <= 1'b0;
      idle(60);
      chk("ignore", 8'h00, {7'h0, seen});
   endtask
   task t_block;
      @(posedge clk);
      trim_request <= 1'b1;
      reset <= 1'b1;
      tick(4);
      reset <= 1'b0;
      idle(80);
      chk("block", 8'h00, {7'h0, seen});
      rd(4'h1);
      chk("armed", 8'h01, {7'h0, d[3]});
      @(posedge clk);
      cmd;
      wtrim(1'b1, 20);
      wtrim(1'b0, 50);
      chk("trlen", 8'h0a, n[7:0]);
      rd(4'h1);
      chk("armed", 8'h00, {7'h0, d[3]});
   endtask
   task t_ext;
      extended_mode_enable <= 1'b1;
      boot(1'b1, 20, 1'b0);
      wr(4'h2, 8'h07);
      tick(3);
      #1 chk("extlvl", 8'h07, {5'h0, range_level, launch_edge,
         swing_level});
      wr(4'h0, 8'h01);
      wtrim(1'b1, 10);
      wtrim(1'b0, 50);
      @(posedge clk);
      extended_mode_enable <= 1'b0;
      {range_select, launch_edge_select, swing_select} <= 3'h7;
      boot(1'b0, 20, 1'b0);
      chk("pinlvl", 8'h07, {5'h0, range_level, launch_edge,
         swing_level});
   endtask
   initial begin
      boot(1'b0, 20, 1'b0);
      t_regs;
      t_data;
      t_sleep;
      boot(1'b1, 40, 1'b0);
      boot(1'b0, 20, 1'b1);
      t_block;
      t_ext;
      finish_test;
   end
endmodule
